/* src/img_mask_group.sv */
// Second interrupt mask group register with masked event gating and interrupt request
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Bit 3 resets to 1 and, while set, keeps the measurement-ready flag from raising the interrupt.
// - Bit 2 resets to 0 and, while set, keeps the supply lockout flag from raising the interrupt.
// - Bit 1 resets to 1 and, while set, keeps the heat warning flag from raising the interrupt.
// - Bit 0 resets to 1 and, while clear, lets any change of the two-bit temperature level after the first edge out of reset raise the interrupt.
module img_mask_group (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [7:0]                    reg_addr_i,
  input  wire logic                          reg_wr_i,
  input  wire logic [img_pkg::IMG_DATA_W-1:0] reg_wdata_i,
  output logic [img_pkg::IMG_DATA_W-1:0]     reg_rdata_o,
  input  wire logic                          measure_done_flag_i,
  input  wire logic                          low_supply_lockout_flag_i,
  input  wire logic                          heat_warning_flag_i,
  input  wire logic [img_pkg::IMG_TEMP_W-1:0] temp_level_i,
  output logic                               irq_req_o,
  output logic [3:0]                         irq_block_o
);
  import img_pkg::*;
  // ********************************
  // Register
  // ********************************
  logic [IMG_DATA_W-1:0] mask_reg;
  logic [IMG_DATA_W-1:0] mask_next;
  logic                  hit_mask;
  logic                  temp_change;
  logic                  measure_done_irq_block;
  logic                  low_supply_irq_block;
  logic                  heat_warning_irq_block;
  logic                  temp_irq_block;
  logic [3:0]            events;
  logic [3:0]            blocks;
  logic                  irq_next;
  logic                  wr_hit;
  logic [3:0]            gated;
  logic [3:0]            block_next;
  logic [IMG_DATA_W-1:0] rdata_next;
  logic                  cause_seen;

  // ********************************
  // Decode helpers
  // ********************************
  // One address compare serves the write strobe, the read mux and the checks
  function automatic logic addr_is_mask(input logic [7:0] addr);
    addr_is_mask = (addr == IMG_MASK_B_ADDR);
  endfunction : addr_is_mask

  // Mask bit that guards each entry of the events vector, measure-ready first
  function automatic int src_bit(input int idx);
    case (idx)
      3:       src_bit = IMG_BIT_MEASURE;
      2:       src_bit = IMG_BIT_SUPPLY;
      1:       src_bit = IMG_BIT_HEAT;
      default: src_bit = IMG_BIT_TEMP;
    endcase
  endfunction : src_bit

  assign hit_mask   = addr_is_mask(reg_addr_i);
  assign wr_hit     = reg_wr_i && hit_mask;
  // Reserved bits are stored too, so they read back as written
  assign mask_next  = wr_hit ? reg_wdata_i : mask_reg;
  // Read data is registered, so it trails the address by one edge
  assign rdata_next = hit_mask ? mask_reg : '0;

  assign measure_done_irq_block = mask_reg[IMG_BIT_MEASURE];
  assign low_supply_irq_block   = mask_reg[IMG_BIT_SUPPLY];
  assign heat_warning_irq_block = mask_reg[IMG_BIT_HEAT];
  assign temp_irq_block         = mask_reg[IMG_BIT_TEMP];

  img_temp_watch #(
    .TEMP_W (IMG_TEMP_W)
  ) u_temp (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .temp_level_i  (temp_level_i),
    .temp_change_o (temp_change)
  );

  // ********************************
  // Interrupt request
  // ********************************
  assign events   = {measure_done_flag_i, low_supply_lockout_flag_i, heat_warning_flag_i, temp_change};
  assign blocks   = {measure_done_irq_block, low_supply_irq_block, heat_warning_irq_block, temp_irq_block};
  assign block_next = blocks;
  for (genvar g = 0; g < 4; g++) begin : g_src
    // A source passes only while the mask bit that guards it is zero
    assign gated[g] = events[g] & ~mask_reg[src_bit(g)];
    chk_src_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      (events[g] && !mask_reg[src_bit(g)]) |=> irq_req_o)
      else $error("Unmasked source did not raise request");
  end
  // Request is level from the flags; clearing flags upstream clears it
  assign irq_next = |gated;

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= IMG_MASK_B_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o <= 1'b0;
    end else begin
      irq_req_o <= irq_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_block_o <= IMG_MASK_B_RESET[3:0];
    end else begin
      irq_block_o <= block_next;
    end
  end

  // ********************************
  // Checks
  // ********************************
  chk_measure_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (measure_done_flag_i && !mask_reg[IMG_BIT_MEASURE]) |=> irq_req_o)
    else $error("Measure-ready unmasked did not raise request");
  chk_supply_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_supply_lockout_flag_i && !mask_reg[IMG_BIT_SUPPLY]) |=> irq_req_o)
    else $error("Lockout unmasked did not raise request");
  chk_heat_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (heat_warning_flag_i && !mask_reg[IMG_BIT_HEAT]) |=> irq_req_o)
    else $error("Heat warning unmasked did not raise request");
  chk_temp_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (temp_change && !mask_reg[IMG_BIT_TEMP]) |=> irq_req_o)
    else $error("Temperature change unmasked did not raise request");
  chk_all_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    (mask_reg[3:0] == 4'hf) |=> !irq_req_o)
    else $error("Request raised with all sources masked");
  chk_reset_value: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (mask_reg == 8'h0b))
    else $error("Mask reset value wrong");
  chk_write_back: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_wr_i && hit_mask) |=> (mask_reg == $past(reg_wdata_i)))
    else $error("Written value not stored");
  chk_read_path: assert property (@(posedge clk_i) disable iff (rst_i)
    hit_mask |=> (reg_rdata_o == $past(mask_reg)))
    else $error("Read data mismatch");

  // ********************************
  // Independent cross-checks
  // ********************************
  // Cause is rebuilt from the flags and mask bits, not from the gating vector
  assign cause_seen = (measure_done_flag_i && !mask_reg[IMG_BIT_MEASURE]) ||
                      (low_supply_lockout_flag_i && !mask_reg[IMG_BIT_SUPPLY]) ||
                      (heat_warning_flag_i && !mask_reg[IMG_BIT_HEAT]) ||
                      (temp_change && !mask_reg[IMG_BIT_TEMP]);

  chk_quiet_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !cause_seen
    |=> !irq_req_o)
    else $error("Request raised with no unmasked event");
  chk_request_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_req_o
    |-> $past(cause_seen))
    else $error("Request raised without a cause");
  chk_block_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i)
    |-> (irq_block_o == $past(mask_reg[3:0])))
    else $error("Mask copy differs from mask bits");
  chk_idle_read: assert property (@(posedge clk_i) disable iff (rst_i)
    !hit_mask
    |=> (reg_rdata_o == '0))
    else $error("Unmapped read returned nonzero data");
  chk_other_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_wr_i && !hit_mask)
    |=> $stable(mask_reg))
    else $error("Write to another address changed the mask");
  chk_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !reg_wr_i
    |=> $stable(mask_reg))
    else $error("Mask changed without a write");
  chk_reserved_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit
    |=> (mask_reg[7:4] == $past(reg_wdata_i[7:4])))
    else $error("Reserved bits not stored as written");
  chk_upper_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (mask_reg[7:4] == 4'h0))
    else $error("Reserved bits not zero after reset");
  chk_reset_outputs: assert property (@(posedge clk_i)
    $fell(rst_i)
    |-> (!irq_req_o && (reg_rdata_o == '0) && (irq_block_o == IMG_MASK_B_RESET[3:0])))
    else $error("Outputs not at reset values");

  // A set mask bit keeps its own source silent while the other sources are idle
  chk_measure_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (mask_reg[IMG_BIT_MEASURE] && !low_supply_lockout_flag_i && !heat_warning_flag_i && !temp_change)
    |=> !irq_req_o)
    else $error("Masked measure-ready flag raised request");
  chk_supply_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (mask_reg[IMG_BIT_SUPPLY] && !measure_done_flag_i && !heat_warning_flag_i && !temp_change)
    |=> !irq_req_o)
    else $error("Masked lockout flag raised request");
  chk_heat_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (mask_reg[IMG_BIT_HEAT] && !measure_done_flag_i && !low_supply_lockout_flag_i && !temp_change)
    |=> !irq_req_o)
    else $error("Masked heat warning raised request");
  chk_temp_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (mask_reg[IMG_BIT_TEMP] && !measure_done_flag_i && !low_supply_lockout_flag_i && !heat_warning_flag_i)
    |=> !irq_req_o)
    else $error("Masked temperature change raised request");
endmodule : img_mask_group
`default_nettype wire

/* src/img_pkg.sv */
// Package of register map, field positions and reset values for the second interrupt mask group
package img_pkg;
  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] IMG_MASK_B_ADDR  = 8'h2e;
  localparam int         IMG_DATA_W       = 8;
  // ********************************
  // Field positions
  // ********************************
  localparam int         IMG_BIT_MEASURE  = 3;
  localparam int         IMG_BIT_SUPPLY   = 2;
  localparam int         IMG_BIT_HEAT     = 1;
  localparam int         IMG_BIT_TEMP     = 0;
  localparam int         IMG_TEMP_W       = 2;
  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0] IMG_MASK_B_RESET = 8'h0b;
  localparam logic [1:0] IMG_TEMP_RESET   = 2'h0;
endpackage : img_pkg

/* src/img_temp_watch.sv */
// Die temperature level change detector
`timescale 1ns/1ps
`default_nettype none
module img_temp_watch #(
  parameter int TEMP_W = 2
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [TEMP_W-1:0] temp_level_i,
  output logic                   temp_change_o
);
  import img_pkg::*;
  // ********************************
  // Change detect
  // ********************************
  // Level comes from logic on this clock, so no synchroniser is needed
  logic [TEMP_W-1:0] last_reg;
  logic              seen_reg;
  logic              change_next;

  assign change_next = seen_reg && (temp_level_i != last_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_reg      <= TEMP_W'(IMG_TEMP_RESET);
      seen_reg      <= 1'b0;
      temp_change_o <= 1'b0;
    end else begin
      last_reg      <= temp_level_i;
      seen_reg      <= 1'b1;
      temp_change_o <= change_next;
    end
  end

  chk_change_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(!rst_i) && !$stable(temp_level_i)) |=> temp_change_o)
    else $error("Temperature change not flagged");
  chk_no_false_change: assert property (@(posedge clk_i) disable iff (rst_i)
    !($past(!rst_i) && !$stable(temp_level_i)) |=> !temp_change_o)
    else $error("Temperature change flagged without a change");
endmodule : img_temp_watch
`default_nettype wire

/* sim/img_mask_group_tb.sv */
// Self-checking testbench for the second interrupt mask group
`timescale 1ns/1ps
`default_nettype none
module img_mask_group_tb;
  import img_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       reg_wr_i = 1'b0;
  logic       irq_req_o;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic [7:0] rd_val;
  logic [2:0] flg = 3'h0;
  logic [1:0] temp_level_i = 2'h0;
  logic [3:0] irq_block_o;
  int         failures = 0;
  int         checks_done = 0;
  img_mask_group dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .measure_done_flag_i(flg[2]),
    .low_supply_lockout_flag_i(flg[1]), .heat_warning_flag_i(flg[0]), .temp_level_i(temp_level_i),
    .irq_req_o(irq_req_o), .irq_block_o(irq_block_o));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    repeat (2) @(posedge clk_i);
    #1 cmp("rdata", exp, reg_rdata_o);
  endtask : rd
  // Watch a window rather than one edge: the pulse from a level change lasts a single cycle
  task automatic ev(input logic [2:0] f, input logic [1:0] t, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clk_i);
    flg          <= f;
    temp_level_i <= t;
    repeat (4) begin
      @(posedge clk_i);
      #1 seen = seen | irq_req_o;
    end
    cmp("irq", {7'h00, exp}, {7'h00, seen});
    @(posedge clk_i);
    flg <= 3'h0;
    repeat (4) @(posedge clk_i);
  endtask : ev
  task automatic t_reset;
    rd(IMG_MASK_B_ADDR, 8'h0b);
    cmp("block", 8'h0b, {4'h0, irq_block_o});
    ev(3'b101, 2'h0, 1'b0);
    ev(3'b010, 2'h0, 1'b1);
    ev(3'b000, 2'h1, 1'b0);
  endtask : t_reset
  task automatic t_rw;
    wr(IMG_MASK_B_ADDR, 8'hf4);
    rd(IMG_MASK_B_ADDR, 8'hf4);
    cmp("block", 8'h04, {4'h0, irq_block_o});
    ev(3'b100, 2'h1, 1'b1);
    ev(3'b001, 2'h1, 1'b1);
    ev(3'b010, 2'h1, 1'b0);
    ev(3'b000, 2'h2, 1'b1);
    wr(8'h2f, 8'h0f);
    rd(8'h2f, 8'h00);
    rd(IMG_MASK_B_ADDR, 8'hf4);
  endtask : t_rw
  // Every source masked at once, with all flags high and a level change
  task automatic t_all_masked;
    wr(IMG_MASK_B_ADDR, 8'h0f);
    rd(IMG_MASK_B_ADDR, 8'h0f);
    cmp("block", 8'h0f, {4'h0, irq_block_o});
    ev(3'b111, 2'h3, 1'b0);
  endtask : t_all_masked
  // Reset in mid-run must bring back the defaults after earlier writes
  task automatic t_mid_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IMG_MASK_B_ADDR, 8'h0b);
    cmp("block", 8'h0b, {4'h0, irq_block_o});
    ev(3'b010, 2'h3, 1'b1);
    ev(3'b101, 2'h0, 1'b0);
  endtask : t_mid_reset
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_rw;
    t_all_masked;
    t_mid_reset;
    print_verdict;
  end
  // Whole run needs about 135 cycles; this limit only cuts a hang
  initial begin
    #20000;
    failures++;
    print_verdict;
  end
endmodule : img_mask_group_tb
`default_nettype wire
